// ### design/tglm_core.sv
// Tone generators, receive gain, digital loop and level meter of a multi-channel codec.
//
// Function
// - Two independent tone generators per channel.
// - Tones switched only by state write command.
// - Coefficient command followed by coefficient bytes.
// - Codes 0C/0D select first/second generator.
// - Active tone without voice-with-tone mutes voice.
// - Reset coefficients give 1000 Hz tones.
// - Four bytes set frequency and bandpass together.
// - Receive gain stages scale the tone amplitude.
// - Digital loop feeds receive signal to transmit.
// - Meter bandpass uses second generator coefficients.
// - Rectify filtered transmit signal, compare to threshold.
// - Result one above threshold, zero below.
// - One shared 8-bit threshold, extended index seven.
// - Result valid 4 ms after enable, refreshed.
// - Meter enable switches off second generator.
// - Only first generator usable while metering.
`timescale 1ns/1ps
`default_nettype none
module tglm_core #(
  parameter int NCH = 4,
  parameter int WIN_CYC = tglm_pkg::METER_WIN_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic sample_tick,
  input wire logic [NCH*16-1:0] rx_in,
  input wire logic [NCH*16-1:0] tx_in,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic [NCH*16-1:0] rx_out,
  output logic [NCH*16-1:0] tx_out
);
  import tglm_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic signed [15:0] tglm_sine(input logic [5:0] ph);
    logic [3:0] idx;
    logic [15:0] mag;
    idx = ph[4] ? ~ph[3:0] : ph[3:0];
    case (idx)
      4'h0: mag = 16'h0000;
      4'h1: mag = 16'h0646;
      4'h2: mag = 16'h0C7C;
      4'h3: mag = 16'h1294;
      4'h4: mag = 16'h187E;
      4'h5: mag = 16'h1E2B;
      4'h6: mag = 16'h238E;
      4'h7: mag = 16'h289A;
      4'h8: mag = 16'h2D41;
      4'h9: mag = 16'h3179;
      4'hA: mag = 16'h3537;
      4'hB: mag = 16'h3871;
      4'hC: mag = 16'h3B21;
      4'hD: mag = 16'h3D3F;
      4'hE: mag = 16'h3EC5;
      default: mag = 16'h3FB1;
    endcase
    tglm_sine = ph[5] ? -$signed(mag) : $signed(mag);
  endfunction : tglm_sine

  function automatic logic signed [15:0] tglm_sat16(input logic signed [17:0] v);
    if (v > 18'sh07FFF) begin
      tglm_sat16 = 16'sh7FFF;
    end else if (v < -18'sh08000) begin
      tglm_sat16 = -16'sh8000;
    end else begin
      tglm_sat16 = v[15:0];
    end
  endfunction : tglm_sat16

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam logic [23:0] WIN_LAST = 24'(WIN_CYC - 1);
  tglm_pstate_e p_state_reg;
  logic [7:0] cmd_reg;
  logic [1:0] cnt_reg;
  logic [7:0] coef_reg [NCH][2][4];
  logic [1:0] tsw_reg [NCH];
  logic [1:0] mvc_reg [NCH];
  logic loop_reg [NCH];
  logic [3:0] gain_reg [NCH];
  logic [7:0] thr_reg;
  logic [15:0] phase_reg [NCH][2];
  logic signed [15:0] tone_reg [NCH][2];
  logic signed [15:0] xprev_reg [NCH];
  logic signed [17:0] lp_reg [NCH];
  logic [39:0] acc_reg [NCH];
  logic [23:0] win_reg [NCH];
  logic result_reg [NCH];
  logic signed [15:0] rxo_reg [NCH];
  logic signed [15:0] txo_reg [NCH];
  logic [1:0] cur_ch;
  logic is_coef_wr, is_state_wr, is_state_rd, is_ext_wr, is_ext_rd;

  assign cur_ch = cmd_reg[7:6];
  assign is_coef_wr = cmd_byte[5:1] == COEF_WR_CODE;
  assign is_state_wr = cmd_byte[5:2] == STATE_WR_CODE;
  assign is_state_rd = cmd_byte[5:2] == STATE_RD_CODE;
  assign is_ext_wr = cmd_byte[7:3] == EXT_WR_CODE;
  assign is_ext_rd = cmd_byte[7:3] == EXT_RD_CODE;

  // ----------------------------------------
  // Command parser
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p_state_reg <= TGLM_P_IDLE;
      cmd_reg <= 8'h00;
      cnt_reg <= 2'h0;
    end else if (cmd_valid) begin
      case (p_state_reg)
        TGLM_P_IDLE: begin
          cmd_reg <= cmd_byte;
          cnt_reg <= 2'h0;
          if (is_coef_wr) begin
            p_state_reg <= TGLM_P_COEF;
          end else if (is_state_wr || is_ext_wr) begin
            p_state_reg <= TGLM_P_DATA;
          end
        end
        TGLM_P_COEF: begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == COEF_LAST) begin
            p_state_reg <= TGLM_P_IDLE;
          end
        end
        TGLM_P_DATA: p_state_reg <= TGLM_P_IDLE;
        default: p_state_reg <= TGLM_P_IDLE;
      endcase
    end
  end

  // Configuration writes; unknown commands and absent channels are dropped silently.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      thr_reg <= THR_RESET;
      for (int c = 0; c < NCH; c++) begin
        tsw_reg[c] <= TSW_RESET;
        mvc_reg[c] <= MVC_RESET;
        loop_reg[c] <= LOOP_RESET;
        gain_reg[c] <= GAIN_RESET;
        for (int g = 0; g < 2; g++) begin
          coef_reg[c][g][0] <= DEF_COEF0;
          coef_reg[c][g][1] <= DEF_COEF1;
          coef_reg[c][g][2] <= DEF_COEF2;
          coef_reg[c][g][3] <= DEF_COEF3;
        end
      end
    end else if (cmd_valid) begin
      if (p_state_reg == TGLM_P_COEF && int'(cur_ch) < NCH) begin
        coef_reg[cur_ch][cmd_reg[0]][cnt_reg] <= cmd_byte;
      end
      if (p_state_reg == TGLM_P_DATA && cmd_reg[7:3] == EXT_WR_CODE) begin
        if (cmd_reg[2:0] == XR_THRESHOLD_IDX) begin
          thr_reg <= cmd_byte;
        end
      end else if (p_state_reg == TGLM_P_DATA && int'(cur_ch) < NCH) begin
        case (cmd_reg[1:0])
          SEL_TONE: begin
            tsw_reg[cur_ch][TSW_FIRST_BIT] <= cmd_byte[TSW_FIRST_BIT];
            tsw_reg[cur_ch][TSW_SECOND_BIT] <= cmd_byte[TSW_SECOND_BIT] &
                                               ~mvc_reg[cur_ch][MVC_METER_BIT];
          end
          SEL_METER: begin
            mvc_reg[cur_ch] <= cmd_byte[1:0];
            if (cmd_byte[MVC_METER_BIT]) begin
              tsw_reg[cur_ch][TSW_SECOND_BIT] <= 1'b0;
            end
          end
          SEL_LOOP: loop_reg[cur_ch] <= cmd_byte[LOOP_BIT];
          default: gain_reg[cur_ch] <= cmd_byte[3:0];
        endcase
      end
    end
  end

  // Reads answer one cycle after the command byte.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      rd_valid <= 1'b0;
      if (cmd_valid && p_state_reg == TGLM_P_IDLE) begin
        if (is_ext_rd) begin
          rd_valid <= 1'b1;
          rd_data <= (cmd_byte[2:0] == XR_THRESHOLD_IDX) ? thr_reg : 8'h00;
        end else if (is_state_rd && int'(cmd_byte[7:6]) < NCH) begin
          rd_valid <= 1'b1;
          case (cmd_byte[1:0])
            SEL_TONE: rd_data <= {6'h00, tsw_reg[cmd_byte[7:6]]};
            SEL_METER: rd_data <= {5'h00, result_reg[cmd_byte[7:6]], mvc_reg[cmd_byte[7:6]]};
            SEL_LOOP: rd_data <= {7'h00, loop_reg[cmd_byte[7:6]]};
            default: rd_data <= {4'h0, gain_reg[cmd_byte[7:6]]};
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Tone generators and receive path
  // ----------------------------------------
  // Gain stages only attenuate by shifts; boost would need a multiplier per channel.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int c = 0; c < NCH; c++) begin
        rxo_reg[c] <= 16'sh0000;
        for (int g = 0; g < 2; g++) begin
          phase_reg[c][g] <= 16'h0000;
          tone_reg[c][g] <= 16'sh0000;
        end
      end
    end else if (sample_tick) begin
      for (int c = 0; c < NCH; c++) begin
        logic signed [17:0] mix;
        logic [2:0] sh;
        mix = 18'sh00000;
        sh = {1'b0, gain_reg[c][1:0]} + {1'b0, gain_reg[c][3:2]};
        for (int g = 0; g < 2; g++) begin
          if (tsw_reg[c][g]) begin
            phase_reg[c][g] <= phase_reg[c][g] + {coef_reg[c][g][0], coef_reg[c][g][1]};
            tone_reg[c][g] <= tglm_sine(phase_reg[c][g][15:10]);
          end else begin
            phase_reg[c][g] <= 16'h0000;
            tone_reg[c][g] <= 16'sh0000;
          end
        end
        if (tsw_reg[c] == 2'h0 || mvc_reg[c][MVC_VWT_BIT]) begin
          mix = 18'(signed'(rx_in[c*16 +: 16]));
        end
        mix = mix + 18'(tone_reg[c][0]) + 18'(tone_reg[c][1]);
        rxo_reg[c] <= tglm_sat16(mix >>> sh);
      end
    end
  end

  // ----------------------------------------
  // Transmit path and level meter
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int c = 0; c < NCH; c++) begin
        txo_reg[c] <= 16'sh0000;
        xprev_reg[c] <= 16'sh0000;
        lp_reg[c] <= 18'sh00000;
      end
    end else if (sample_tick) begin
      for (int c = 0; c < NCH; c++) begin
        logic signed [15:0] src;
        logic signed [17:0] hp;
        logic [2:0] k;
        src = loop_reg[c] ? rxo_reg[c] : signed'(tx_in[c*16 +: 16]);
        k = {1'b0, coef_reg[c][1][3][1:0]} + 3'h1;
        hp = 18'(src) - 18'(xprev_reg[c]);
        txo_reg[c] <= src;
        xprev_reg[c] <= src;
        lp_reg[c] <= lp_reg[c] + ((hp - lp_reg[c]) >>> k);
      end
    end
  end

  // The window restarts whenever metering is off; the last result is held until a new window completes.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int c = 0; c < NCH; c++) begin
        acc_reg[c] <= 40'h0;
        win_reg[c] <= 24'h0;
        result_reg[c] <= 1'b0;
      end
    end else begin
      for (int c = 0; c < NCH; c++) begin
        logic [17:0] rect;
        logic [39:0] lvl;
        rect = lp_reg[c][17] ? 18'(-lp_reg[c]) : 18'(lp_reg[c]);
        lvl = acc_reg[c] >> LEVEL_SHIFT;
        if (!mvc_reg[c][MVC_METER_BIT]) begin
          acc_reg[c] <= 40'h0;
          win_reg[c] <= 24'h0;
        end else if (win_reg[c] == WIN_LAST) begin
          win_reg[c] <= 24'h0;
          acc_reg[c] <= 40'h0;
          result_reg[c] <= (lvl > 40'(thr_reg));
        end else begin
          win_reg[c] <= win_reg[c] + 24'h1;
          if (sample_tick) begin
            acc_reg[c] <= acc_reg[c] + 40'(rect);
          end
        end
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      rx_out[c*16 +: 16] = rxo_reg[c];
      tx_out[c*16 +: 16] = txo_reg[c];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Data bytes may follow their command directly or after one idle cycle.
  sequence seq_state_tone0;
    cmd_valid && p_state_reg == TGLM_P_IDLE && cmd_byte == {2'h0, STATE_WR_CODE, SEL_TONE};
  endsequence
  sequence seq_ext_thr;
    cmd_valid && p_state_reg == TGLM_P_IDLE && cmd_byte == {EXT_WR_CODE, XR_THRESHOLD_IDX};
  endsequence

  tone_switch_wr_a: assert property (@(posedge clk) disable iff (!nrst)
    seq_state_tone0 ##[1:2]
    (cmd_valid && p_state_reg == TGLM_P_DATA && !mvc_reg[0][MVC_METER_BIT])
    |=> tsw_reg[0] == 2'($past(cmd_byte)))
    else $error("tone switch write not applied");
  thr_write_a: assert property (@(posedge clk) disable iff (!nrst)
    seq_ext_thr ##[1:2] (cmd_valid && p_state_reg == TGLM_P_DATA)
    |=> thr_reg == $past(cmd_byte))
    else $error("threshold write not applied");
  coef_second_a: assert property (@(posedge clk) disable iff (!nrst)
    (cmd_valid && p_state_reg == TGLM_P_COEF && cnt_reg == COEF_LAST && cmd_reg == 8'h0D)
    |=> coef_reg[0][1][3] == $past(cmd_byte) && p_state_reg == TGLM_P_IDLE)
    else $error("second generator coefficient not stored");
  meter_stops_second_a: assert property (@(posedge clk) disable iff (!nrst)
    mvc_reg[0][MVC_METER_BIT] |-> !tsw_reg[0][TSW_SECOND_BIT])
    else $error("second generator on while metering");
  // A generator just switched off still holds its last sample for one tick.
  voice_mute_a: assert property (@(posedge clk) disable iff (!nrst)
    (sample_tick && tsw_reg[0] == 2'h1 && !mvc_reg[0][MVC_VWT_BIT] && gain_reg[0] == 4'h0
     && tone_reg[0][1] == 16'sh0000)
    |=> rxo_reg[0] == $past(tone_reg[0][0]))
    else $error("voice not muted under tone");
  voice_pass_a: assert property (@(posedge clk) disable iff (!nrst)
    (sample_tick && tsw_reg[0] == 2'h0 && gain_reg[0] == 4'h0
     && tone_reg[0][0] == 16'sh0000 && tone_reg[0][1] == 16'sh0000)
    |=> rxo_reg[0] == 16'($past(rx_in)))
    else $error("voice not passed");
  dig_loop_a: assert property (@(posedge clk) disable iff (!nrst)
    (sample_tick && loop_reg[0]) |=> txo_reg[0] == $past(rxo_reg[0]))
    else $error("digital loop not routed");
  win_start_a: assert property (@(posedge clk) disable iff (!nrst)
    !mvc_reg[0][MVC_METER_BIT] ##1 mvc_reg[0][MVC_METER_BIT] |-> win_reg[0] == 24'h0)
    else $error("meter window not restarted");
  result_cmp_a: assert property (@(posedge clk) disable iff (!nrst)
    (mvc_reg[0][MVC_METER_BIT] && win_reg[0] == WIN_LAST)
    |=> result_reg[0] == (($past(acc_reg[0]) >> LEVEL_SHIFT) > 40'($past(thr_reg)))
        && win_reg[0] == 24'h0)
    else $error("compare result wrong");
  read_ans_a: assert property (@(posedge clk) disable iff (!nrst)
    (cmd_valid && p_state_reg == TGLM_P_IDLE && is_ext_rd) |=> rd_valid ##1 !rd_valid)
    else $error("read answer missing");
endmodule : tglm_core
`default_nettype wire

// ### design/tglm_pkg.sv
// Constants, field layouts and encodings of the tone generator and level meter block.
package tglm_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int METER_WIN_US = 4000;
  localparam int METER_WIN_CYC = (CLK_HZ / 1_000_000) * METER_WIN_US;
  // ----------------------------------------
  // Command byte encodings
  // ----------------------------------------
  localparam logic [4:0] COEF_WR_CODE = 5'h06;
  localparam logic [3:0] STATE_WR_CODE = 4'h4;
  localparam logic [3:0] STATE_RD_CODE = 4'h5;
  localparam logic [4:0] EXT_WR_CODE = 5'h04;
  localparam logic [4:0] EXT_RD_CODE = 5'h05;
  localparam logic [2:0] XR_THRESHOLD_IDX = 3'h7;
  localparam logic [1:0] SEL_TONE = 2'h0;
  localparam logic [1:0] SEL_METER = 2'h1;
  localparam logic [1:0] SEL_LOOP = 2'h2;
  localparam logic [1:0] SEL_GAIN = 2'h3;
  localparam logic [1:0] COEF_LAST = 2'h3;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int TSW_FIRST_BIT = 0;
  localparam int TSW_SECOND_BIT = 1;
  localparam int MVC_VWT_BIT = 0;
  localparam int MVC_METER_BIT = 1;
  localparam int MVC_RESULT_BIT = 2;
  localparam int LOOP_BIT = 0;
  localparam logic [1:0] TSW_RESET = 2'h0;
  localparam logic [1:0] MVC_RESET = 2'h0;
  localparam logic LOOP_RESET = 1'h0;
  localparam logic [3:0] GAIN_RESET = 4'h0;
  localparam logic [7:0] THR_RESET = 8'h80;
  localparam logic [7:0] DEF_COEF0 = 8'h1B;
  localparam logic [7:0] DEF_COEF1 = 8'h3B;
  localparam logic [7:0] DEF_COEF2 = 8'h50;
  localparam logic [7:0] DEF_COEF3 = 8'h87;
  localparam int LEVEL_SHIFT = 12;
  // ----------------------------------------
  // Command parser states
  // ----------------------------------------
  typedef enum logic [2:0] {
    TGLM_P_IDLE = 3'b001,
    TGLM_P_COEF = 3'b010,
    TGLM_P_DATA = 3'b100
  } tglm_pstate_e;
endpackage : tglm_pkg

// ### test/tglm_host.sv
// Host controller model that sends command bytes and collects read answers.
`timescale 1ns/1ps
`default_nettype none
module tglm_host (
  input wire logic clk,
  output logic cmd_valid,
  output logic [7:0] cmd_byte,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
  end
  // Idle lines carry the inverse of the last byte, so stale data never passes for valid.
  task automatic put_byte(input logic [7:0] b);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_byte <= b;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_byte <= ~b;
  endtask : put_byte
  // Settings other than coefficients change only through a state or extended write and its data byte.
  task automatic write_pair(input logic [7:0] c, input logic [7:0] d);
    put_byte(c);
    put_byte(d);
  endtask : write_pair
  // The coefficient bytes follow their command one idle cycle apart, first byte first.
  task automatic write_coef(input logic [7:0] c, input logic [31:0] b);
    put_byte(c);
    for (int i = 3; i >= 0; i--) begin
      put_byte(b[i*8+:8]);
    end
  endtask : write_coef
  task automatic read_reg(input logic [7:0] c, output logic got, output logic [7:0] d);
    put_byte(c);
    @(posedge clk);
    got = rd_valid;
    d = rd_data;
  endtask : read_reg
  // A result is fetched only after a full metering window has run.
  task automatic wait_window(input int win);
    repeat (win + 8) @(posedge clk);
  endtask : wait_window
endmodule : tglm_host
`default_nettype wire

// ### test/testbench.sv
// Self-checking testbench of the tone generator and level meter block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tglm_pkg::*;
  localparam int WIN = 64;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic sample_tick = 1'b0;
  logic tick_en = 1'b1;
  logic [1:0] tick_cnt = 2'h0;
  logic [63:0] rx_in = 64'h0;
  logic [63:0] tx_set = 64'h0;
  logic [15:0] sq_reg = 16'h7000;
  logic sq_en = 1'b0;
  wire logic [63:0] tx_in;
  logic cmd_valid;
  logic [7:0] cmd_byte;
  logic rd_valid;
  logic [7:0] rd_data;
  logic [63:0] rx_out;
  logic [63:0] tx_out;
  logic seen;
  logic res;
  int lo_t = 0;
  int hi_t = 255;
  int mid_t = 128;
  int n_mismatch = 0;
  int n_checks = 0;
  always #2.5 clk = ~clk;
  // Samples are ticked every fourth clock; gating lets several channels start in step.
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 2'h1;
    sample_tick <= tick_en && (tick_cnt == 2'h3);
    if (sample_tick) begin
      sq_reg <= 16'h0000 - sq_reg;
    end
  end
  // A square wave at half the sample rate gives the meter a level that repeats every window.
  assign tx_in = sq_en ? {tx_set[63:16], sq_reg} : tx_set;
  tglm_core #(.NCH(4), .WIN_CYC(WIN)) dut (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .sample_tick(sample_tick), .rx_in(rx_in), .tx_in(tx_in),
    .rd_valid(rd_valid), .rd_data(rd_data), .rx_out(rx_out), .tx_out(tx_out));
  tglm_host host (.clk(clk), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .rd_valid(rd_valid), .rd_data(rd_data));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] sw(input int c, input logic [1:0] s);
    return {c[1:0], STATE_WR_CODE, s};
  endfunction : sw
  function automatic logic [7:0] sr(input int c, input logic [1:0] s);
    return {c[1:0], STATE_RD_CODE, s};
  endfunction : sr
  function automatic logic [15:0] ch(input logic [63:0] v, input int c);
    return v[c*16+:16];
  endfunction : ch
  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk_byte
  task automatic chk_word(input string what, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : chk_word
  // A missing answer is turned into unknowns so that it can never match.
  task automatic rd(input logic [7:0] c, input logic [7:0] e, input string what);
    logic v;
    logic [7:0] d;
    host.read_reg(c, v, d);
    chk_byte(what, e, (v === 1'b1) ? d : 8'hXX);
  endtask : rd
  task automatic nr(input logic [7:0] b);
    host.put_byte(b);
    @(posedge clk);
    chk_byte("no answer", 8'h00, {7'h00, rd_valid});
  endtask : nr
  task automatic ticks(input int n);
    repeat (n * 4) @(posedge clk);
  endtask : ticks
  // Each step waits a whole window after the threshold changes, so the result is fresh.
  task automatic meter_at(input logic [7:0] t, output logic r);
    logic v;
    logic [7:0] d;
    host.write_pair({EXT_WR_CODE, XR_THRESHOLD_IDX}, t);
    host.wait_window(WIN);
    host.read_reg(sr(0, SEL_METER), v, d);
    chk_byte("meter config", 8'h02, (v === 1'b1) ? (d & 8'h03) : 8'hXX);
    r = d[MVC_RESULT_BIT];
  endtask : meter_at
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      for (int s = 0; s < 4; s++) begin
        rd(sr(c, s[1:0]), 8'h00, "reset state");
      end
    end
    rd({EXT_RD_CODE, XR_THRESHOLD_IDX}, THR_RESET, "threshold reset");
    rd({EXT_RD_CODE, 3'h3}, 8'h00, "unmapped extended");
    $display("test reset done");
    nr(8'hFF);
    nr(8'h0C);
    nr(8'h27);
    nr(8'h00);
    nr(8'h15);
    nr(8'h15);
    rd({EXT_RD_CODE, XR_THRESHOLD_IDX}, THR_RESET, "threshold kept");
    host.write_pair({EXT_WR_CODE, XR_THRESHOLD_IDX}, 8'h5A);
    rd({EXT_RD_CODE, XR_THRESHOLD_IDX}, 8'h5A, "threshold write");
    // The bytes above reprogrammed channel 0; restore it so it matches untouched channels.
    host.write_coef(8'h0C, {DEF_COEF0, DEF_COEF1, DEF_COEF2, DEF_COEF3});
    $display("test commands done");
    rx_in <= {16'h0000, 16'h1000, 16'h0000, 16'h1234};
    ticks(3);
    for (int c = 0; c < 4; c++) begin
      chk_word("voice pass", ch(rx_in, c), ch(rx_out, c));
    end
    tick_en <= 1'b0;
    ticks(2);
    host.write_pair(sw(2, SEL_METER), 8'h01);
    host.write_pair(sw(3, SEL_METER), 8'h01);
    for (int c = 0; c < 4; c++) begin
      host.write_pair(sw(c, SEL_TONE), 8'h01);
    end
    tick_en <= 1'b1;
    rd(sr(0, SEL_TONE), 8'h01, "tone switch");
    seen = 1'b0;
    for (int i = 0; i < 24; i++) begin
      ticks(1);
      chk_word("muted voice", ch(rx_out, 1), ch(rx_out, 0));
      chk_word("voice with tone", 16'h1000, ch(rx_out, 2) - ch(rx_out, 3));
      seen = seen | (ch(rx_out, 1) != 16'h0000);
    end
    chk_byte("tone present", 8'h01, {7'h00, seen});
    $display("test tones done");
    for (int c = 0; c < 4; c++) begin
      host.write_pair(sw(c, SEL_TONE), 8'h00);
    end
    host.write_pair(sw(0, SEL_GAIN), 8'h06);
    tx_set <= 64'h0555;
    ticks(3);
    chk_word("gain", 16'h0246, ch(rx_out, 0));
    chk_word("loop off", 16'h0555, ch(tx_out, 0));
    host.write_pair(sw(0, SEL_LOOP), 8'h01);
    ticks(3);
    chk_word("loop on", 16'h0246, ch(tx_out, 0));
    $display("test gain loop done");
    host.write_pair(sw(0, SEL_GAIN), 8'h00);
    host.write_coef(8'h0C, {DEF_COEF0, DEF_COEF1, DEF_COEF2, DEF_COEF3});
    host.write_coef(8'h0D, {DEF_COEF0, DEF_COEF1, DEF_COEF2, DEF_COEF3});
    host.write_pair({EXT_WR_CODE, XR_THRESHOLD_IDX}, 8'h00);
    host.write_pair(sw(0, SEL_TONE), 8'h03);
    rd(sr(0, SEL_TONE), 8'h03, "both tones");
    host.write_pair(sw(0, SEL_METER), 8'h02);
    rd(sr(0, SEL_TONE), 8'h01, "meter stops second");
    host.write_pair(sw(0, SEL_TONE), 8'h03);
    rd(sr(0, SEL_TONE), 8'h01, "second refused");
    rd(sr(0, SEL_METER), 8'h02, "result early");
    host.wait_window(WIN);
    rd(sr(0, SEL_METER), 8'h06, "result above");
    host.write_pair(sw(0, SEL_LOOP), 8'h00);
    host.write_pair(sw(0, SEL_TONE), 8'h00);
    tx_set <= 64'h0;
    for (int i = 0; i < 4; i++) begin
      host.wait_window(WIN);
    end
    rd(sr(0, SEL_METER), 8'h02, "result equal");
    $display("test meter done");
    // Metering stays on channel 0, an even channel, so no partner channel must be held up.
    sq_en <= 1'b1;
    host.wait_window(WIN * 10);
    while (hi_t - lo_t > 1) begin
      meter_at(mid_t[7:0], res);
      if (res) begin
        lo_t = mid_t;
      end else begin
        hi_t = mid_t;
      end
      mid_t = (lo_t + hi_t + 1) / 2;
    end
    meter_at(lo_t[7:0], res);
    chk_byte("level above lower byte", 8'h01, {7'h00, res});
    meter_at(hi_t[7:0], res);
    chk_byte("level below upper byte", 8'h00, {7'h00, res});
    $display("test search done");
    test_done();
  end
endmodule : testbench
`default_nettype wire
